/* iob_option_bank.sv */
// I/O option register bank reached over AXI4-Lite, driving port configuration levels.
// Assumes aresetn is the power-on reset, synchronous to aclk; other resets never reach here.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// [R1] Option registers load zero only at power-on reset, then change only by writes.
// [R2] Watchdog and port A input resets leave all option registers unchanged.
// [R3] Register 76 picks interrupt edge per port A bit; zero means positive edge.
// [R4] Register 77 bit set removes port A pull-down; cleared keeps it.
// [R5] Register 78 bit set removes port B pull-down; cleared keeps it.
// [R6] Register 79 bit set gives port B open-drain; cleared gives push-pull.
// [R7] Register 7A holds strobe select, port C open-drain and port C pull-down disable.
// [R8] Register 7B selects which internal frequency drives out on port B.
// [R9] Registers 7C and 7D choose port A inputs taking part in reset combination.
// [R10] Port B pull-up is enabled only on pins in open-drain mode.
// [R11] Writing register 7F in test mode copies accumulator onto port B outputs.
// [R12] Register 75 bit set bypasses port A debouncer for interrupts; default keeps it.
module iob_option_bank
  import iob_pkg::*;
(
  // Clock and power-on reset
  input wire logic aclk,
  input wire logic aresetn,
  // Factory test
  input wire logic test_mode,
  input wire logic [3:0] accu,
  // AXI4-Lite write address and data
  input wire logic [IOB_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [IOB_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port configuration
  output iob_ctl_s port_ctl
);

  iob_state_s s_q;
  iob_state_s s_d;

  function automatic logic [7:0] idx_of(input logic [IOB_ADDR_W-1:0] a);
    idx_of = a[IOB_ADDR_W-1:IOB_IDX_LSB];
  endfunction : idx_of

  function automatic logic is_opt(input logic [7:0] i);
    is_opt = (i >= IOB_IDX_FIRST) && (i <= IOB_IDX_RSEL2);
  endfunction : is_opt

  logic [IOB_NREG*4-1:0] opt_flat;
  logic [3:0] rd_nib;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic wr_ok;
  logic rd_ok;

  // Registers held in struct in reverse of index order
  assign opt_flat = s_q.opt;

  always_comb begin
    s_d = s_q;
    wr_idx = idx_of(s_q.aw_addr);
    rd_idx = idx_of(s_axi_araddr);
    rd_nib = 4'h0;
    wr_ok = 1'b0;
    rd_ok = is_opt(rd_idx);
    s_d.ctl.pb_test_valid = 1'b0;
    if (rd_ok) begin
      rd_nib = opt_flat[(IOB_NREG-1-(rd_idx-IOB_IDX_FIRST))*4 +: 4];
    end
    // Capture address and data in either order
    if (s_axi_awvalid && s_q.axi.awready) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
      s_d.axi.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.axi.wready) begin
      s_d.w_held = 1'b1;
      s_d.w_data = s_axi_wdata[3:0];
      s_d.w_strb0 = s_axi_wstrb[0];
      s_d.axi.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.axi.bvalid) begin
      wr_ok = is_opt(wr_idx) || (wr_idx == IOB_IDX_TEST);
      s_d.axi.bvalid = 1'b1;
      s_d.axi.bresp = wr_ok ? IOB_RESP_OKAY : IOB_RESP_SLVERR;
      if (s_q.w_strb0) begin
        case (wr_idx)
          IOB_IDX_DEB_BYP: s_d.opt.porta_irq_debounce_bypass = s_q.w_data; // [R1] [R12]
          IOB_IDX_EDGE: s_d.opt.porta_irq_edge_select = s_q.w_data; // [R3]
          IOB_IDX_PA_NOPD: s_d.opt.porta_pulldown_disable = s_q.w_data; // [R4]
          IOB_IDX_PB_NOPD: s_d.opt.portb_pulldown_disable = s_q.w_data; // [R5]
          IOB_IDX_PB_OD: s_d.opt.portb_open_drain_select = s_q.w_data; // [R6]
          IOB_IDX_PC_STR: s_d.opt.portc_and_strobe_config = s_q.w_data; // [R7]
          IOB_IDX_FREQ: s_d.opt.portb_freq_out_select = s_q.w_data; // [R8]
          IOB_IDX_RSEL1: s_d.opt.porta_reset_select_first = s_q.w_data; // [R9]
          IOB_IDX_RSEL2: s_d.opt.porta_reset_select_second = s_q.w_data; // [R9]
          IOB_IDX_TEST: begin
            if (test_mode) begin
              s_d.ctl.pb_test_data = accu; // [R11]
              s_d.ctl.pb_test_valid = 1'b1; // [R11]
            end
          end
          default: begin
          end
        endcase
      end
    end
    if (s_q.axi.bvalid && s_axi_bready) begin
      s_d.axi.bvalid = 1'b0;
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.axi.awready = 1'b1;
      s_d.axi.wready = 1'b1;
    end
    // Read: address taken when no answer is pending
    if (s_axi_arvalid && s_q.axi.arready) begin
      s_d.axi.arready = 1'b0;
      s_d.axi.rvalid = 1'b1;
      s_d.axi.rdata = {28'h000_0000, rd_nib};
      s_d.axi.rresp = rd_ok ? IOB_RESP_OKAY : IOB_RESP_SLVERR;
    end
    if (s_q.axi.rvalid && s_axi_rready) begin
      s_d.axi.rvalid = 1'b0;
      s_d.axi.arready = 1'b1;
    end
    // Configuration levels follow the option registers
    s_d.ctl.pa_irq_deb_bypass = s_d.opt.porta_irq_debounce_bypass; // [R12]
    s_d.ctl.pa_irq_edge_neg = s_d.opt.porta_irq_edge_select; // [R3]
    s_d.ctl.pa_pulldown_en = ~s_d.opt.porta_pulldown_disable; // [R4]
    s_d.ctl.pb_pulldown_en = ~s_d.opt.portb_pulldown_disable; // [R5]
    s_d.ctl.pb_open_drain = s_d.opt.portb_open_drain_select; // [R6]
    s_d.ctl.pb_pullup_en = s_d.opt.portb_open_drain_select; // [R10]
    s_d.ctl.strobe_sel = s_d.opt.portc_and_strobe_config[IOB_STR_LSB +: 2]; // [R7]
    s_d.ctl.pc_open_drain = s_d.opt.portc_and_strobe_config[IOB_PC_OD_BIT]; // [R7]
    s_d.ctl.pc_pulldown_en = ~s_d.opt.portc_and_strobe_config[IOB_PC_NOPD_BIT]; // [R7]
    s_d.ctl.pb_freq_sel = s_d.opt.portb_freq_out_select; // [R8]
    s_d.ctl.pa_rst_sel_first = s_d.opt.porta_reset_select_first; // [R9]
    s_d.ctl.pa_rst_sel_second = s_d.opt.porta_reset_select_second; // [R9]
  end

  // Only power-on reset reaches this bank; watchdog and port A resets do not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0; // [R1] [R2]
      s_q.opt <= {IOB_NREG{IOB_OPT_RESET}}; // [R1]
      s_q.axi.awready <= 1'b1;
      s_q.axi.wready <= 1'b1;
      s_q.axi.arready <= 1'b1;
      s_q.ctl.pa_pulldown_en <= 4'hf;
      s_q.ctl.pb_pulldown_en <= 4'hf;
      s_q.ctl.pc_pulldown_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.axi.awready;
  assign s_axi_wready = s_q.axi.wready;
  assign s_axi_bvalid = s_q.axi.bvalid;
  assign s_axi_bresp = s_q.axi.bresp;
  assign s_axi_arready = s_q.axi.arready;
  assign s_axi_rvalid = s_q.axi.rvalid;
  assign s_axi_rdata = s_q.axi.rdata;
  assign s_axi_rresp = s_q.axi.rresp;
  assign port_ctl = s_q.ctl;

endmodule : iob_option_bank
`default_nettype wire

/* iob_pkg.sv */
// Package for the I/O option register bank: offsets, reset values, field layout, types.
// Assumes a 32-bit AXI4-Lite register bus; each option register takes one aligned word.
package iob_pkg;

  // Byte address is four times an eight-bit index, so ten address bits are used
  localparam int unsigned IOB_ADDR_W = 10;
  localparam int unsigned IOB_NIB_W = 4;

  // Printed offsets are not all multiples of four: these are indices, byte address is 4x
  localparam logic [7:0] IOB_IDX_DEB_BYP = 8'h75;
  localparam logic [7:0] IOB_IDX_EDGE = 8'h76;
  localparam logic [7:0] IOB_IDX_PA_NOPD = 8'h77;
  localparam logic [7:0] IOB_IDX_PB_NOPD = 8'h78;
  localparam logic [7:0] IOB_IDX_PB_OD = 8'h79;
  localparam logic [7:0] IOB_IDX_PC_STR = 8'h7a;
  localparam logic [7:0] IOB_IDX_FREQ = 8'h7b;
  localparam logic [7:0] IOB_IDX_RSEL1 = 8'h7c;
  localparam logic [7:0] IOB_IDX_RSEL2 = 8'h7d;
  localparam logic [7:0] IOB_IDX_TEST = 8'h7f;
  localparam logic [7:0] IOB_IDX_FIRST = 8'h75;
  localparam int unsigned IOB_NREG = 9;
  localparam int unsigned IOB_IDX_LSB = 2;

  localparam logic [3:0] IOB_OPT_RESET = 4'h0;

  // portc_and_strobe_config fields
  localparam int unsigned IOB_STR_LSB = 0;
  localparam int unsigned IOB_PC_OD_BIT = 2;
  localparam int unsigned IOB_PC_NOPD_BIT = 3;

  localparam logic [1:0] IOB_RESP_OKAY = 2'h0;
  localparam logic [1:0] IOB_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] porta_irq_debounce_bypass;
    logic [3:0] porta_irq_edge_select;
    logic [3:0] porta_pulldown_disable;
    logic [3:0] portb_pulldown_disable;
    logic [3:0] portb_open_drain_select;
    logic [3:0] portc_and_strobe_config;
    logic [3:0] portb_freq_out_select;
    logic [3:0] porta_reset_select_first;
    logic [3:0] porta_reset_select_second;
  } iob_opt_s;

  typedef struct packed {
    logic [3:0] pa_pulldown_en;
    logic [3:0] pa_irq_edge_neg;
    logic [3:0] pa_irq_deb_bypass;
    logic [3:0] pa_rst_sel_first;
    logic [3:0] pa_rst_sel_second;
    logic [3:0] pb_pulldown_en;
    logic [3:0] pb_pullup_en;
    logic [3:0] pb_open_drain;
    logic [3:0] pb_freq_sel;
    logic [3:0] pb_test_data;
    logic pb_test_valid;
    logic [1:0] strobe_sel;
    logic pc_open_drain;
    logic pc_pulldown_en;
  } iob_ctl_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iob_axi_s;

  typedef struct packed {
    iob_opt_s opt;
    logic aw_held;
    logic [IOB_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [3:0] w_data;
    logic w_strb0;
    iob_axi_s axi;
    iob_ctl_s ctl;
  } iob_state_s;

endpackage : iob_pkg

/* iob_option_bank_chk.sv */
// Checker for the option register bank: bus timing and port control levels.
// Assumes it is bound to iob_option_bank and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module iob_option_bank_chk
  import iob_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Port configuration
  input wire iob_ctl_s port_ctl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ctl_hold: assert property ($past(aresetn) && !$rose(s_axi_bvalid)
    && !$past(port_ctl.pb_test_valid)
    |-> $stable(port_ctl)) else $error("port control moved without a write");
  chk_por_values: assert property ($rose(aresetn) |-> port_ctl.pa_irq_edge_neg == 4'h0
    && port_ctl.pa_pulldown_en == 4'hf && port_ctl.pb_pulldown_en == 4'hf
    && port_ctl.pb_open_drain == 4'h0 && port_ctl.pc_pulldown_en
    && port_ctl.pa_irq_deb_bypass == 4'h0) else $error("wrong power-up level");
  chk_pullup_od: assert property (port_ctl.pb_pullup_en == port_ctl.pb_open_drain)
    else $error("pull-up outside open drain");
  chk_test_pulse: assert property (port_ctl.pb_test_valid |-> $rose(s_axi_bvalid)
    ##1 !port_ctl.pb_test_valid) else $error("test drive pulse wrong");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  chk_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready && s_axi_wready) else $error("write not closed");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
    && !s_axi_arready) else $error("read answer late");
  chk_read_data: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0
    && (s_axi_rresp == IOB_RESP_OKAY || s_axi_rdata == 32'h0)) else $error("read data wide");
  chk_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
    && s_axi_arready) else $error("read not closed");
  cover property (port_ctl.pb_test_valid);
  cover property (s_axi_bvalid && s_axi_bresp == IOB_RESP_SLVERR);
  cover property (s_axi_rvalid && s_axi_rdata != 32'h0);
endmodule : iob_option_bank_chk
bind iob_option_bank iob_option_bank_chk u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .port_ctl);
`default_nettype wire

/* tb.sv */
// Testbench for the option register bank: random bus traffic, queued expectations.
// Assumes iob_pkg and iob_option_bank; the checker is bound separately.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import iob_pkg::*;
  logic aclk = 0, aresetn = 0, tm = 0, awv = 0, wv = 0, arv = 0;
  logic [3:0] accu = 0, ws = 0, td = 0;
  logic [9:0] awa = 0, ara = 0;
  logic [7:0] a;
  logic [31:0] wd = 0, seed = 32'hc1c8, rdat;
  logic [3:0] m [9] = '{default: 4'h0};
  logic [5:0] qb [$];
  logic [33:0] qr [$];
  logic awr, wrd, bv, arr, rv;
  logic [1:0] br, rr;
  iob_ctl_s pc;
  int n_mismatch = 0, compares = 0;
  iob_option_bank uut (.aclk, .aresetn, .test_mode(tm), .accu, .s_axi_awaddr(awa),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .port_ctl(pc));
  always #12.5 aclk = ~aclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic stop_test();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Returns at the rising edge where the selected answer is high
  task automatic wait_for(input int s);
    int i;
    logic r;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      r = (s == 0) ? awr : (s == 1) ? wrd : (s == 2) ? bv : (s == 3) ? arr : rv;
      if (r === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      stop_test();
    end
    @(posedge aclk);
  endtask : wait_for
  // Port levels against the register model, looked at mid-cycle
  task automatic chk_ctl();
    @(negedge aclk);
    chk("ctl_a", 34'({m[0], m[1], ~m[2], ~m[3], m[4]}), 34'({pc.pa_irq_deb_bypass,
      pc.pa_irq_edge_neg, pc.pa_pulldown_en, pc.pb_pulldown_en, pc.pb_open_drain}));
    chk("ctl_b", 34'({m[4], m[5], m[6], m[7], m[8]}), 34'({pc.pb_pullup_en,
      ~pc.pc_pulldown_en, pc.pc_open_drain, pc.strobe_sel, pc.pb_freq_sel,
      pc.pa_rst_sel_first, pc.pa_rst_sel_second}));
    @(posedge aclk);
  endtask : chk_ctl
  task automatic wr(input logic [7:0] x);
    logic [31:0] d;
    d = xs();
    {awa, wd, ws, tm, accu} <= {x, 2'b00, d, d[11:8], d[12], d[19:16]};
    {awv, wv} <= 2'b11;
    if (x inside {[8'h75:8'h7d]}) begin
      if (d[8]) m[x - 8'h75] = d[3:0];
      qb.push_back({IOB_RESP_OKAY, td});
    end else begin
      if (x == 8'h7f && d[12] && d[8]) td = d[19:16];
      qb.push_back({(x == 8'h7f) ? IOB_RESP_OKAY : IOB_RESP_SLVERR, td});
    end
    fork
      begin
        wait_for(0);
        awv <= 1'b0;
      end
      begin
        wait_for(1);
        wv <= 1'b0;
      end
    join
    wait_for(2);
    chk_ctl();
  endtask : wr
  task automatic rd(input logic [7:0] x);
    ara <= {x, 2'b00};
    arv <= 1'b1;
    if (x inside {[8'h75:8'h7d]}) qr.push_back({IOB_RESP_OKAY, 28'h0, m[x - 8'h75]});
    else qr.push_back({IOB_RESP_SLVERR, 32'h0});
    wait_for(3);
    arv <= 1'b0;
    wait_for(4);
  endtask : rd
  always @(negedge aclk) begin
    if (aresetn && bv) chk("bresp_testdata", 34'(qb.pop_front()), {28'h0, br, pc.pb_test_data});
    if (aresetn && rv) chk("rresp_rdata", qr.pop_front(), {rr, rdat});
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int x = 8'h74; x < 8'h80; x++) rd(8'(x));
    repeat (80) begin
      a = 8'h74 + 8'(xs() % 32'd12);
      wr(a);
      rd(a);
    end
    // Second power-on reset in mid-run brings every option back to zero
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    m = '{default: 4'h0};
    td = 4'h0;
    chk_ctl();
    for (int x = 8'h74; x < 8'h80; x++) rd(8'(x));
    stop_test();
  end
endmodule : tb
`default_nettype wire
